// ==== core/ocp_cal_pkg.sv ====
// Constants, register map and carrier types of the overcurrent/calibration block
package ocp_cal_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS   = 8'h08;
    localparam logic [7:0] STATE_OFS  = 8'h0c;

    // Control register fields
    localparam int TRIP_LSB  = 0;  // 4 bits, code 0 = 0.06 V, 15 = 1.88 V
    localparam int DGL_LSB   = 4;  // 2 bits, deglitch select
    localparam int LSREF_BIT = 6;  // 0 positive sense, 1 negative sense
    localparam int GAIN_LSB  = 7;  // 2 bits, 5/10/20/40 V/V
    localparam int VDIV_BIT  = 9;  // 1 removes divider, unidirectional
    localparam int CAL_LSB   = 10; // 3 bits, per channel calibration
    localparam int CTRL_W    = 13;
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;

    // Status layout: 6 overcurrent events then 3 trim-done events
    localparam int STAT_W = 9;
    localparam int DONE_LSB = 6;
    localparam logic [STAT_W-1:0] STAT_RST = 9'h000;
    localparam logic [STAT_W-1:0] MASK_RST = 9'h000;

    // Gain codes
    localparam logic [1:0] GAIN_40 = 2'h3;

    // Timing
    localparam int CLK_HZ   = 25_000_000;
    localparam int TRIM_US  = 100;
    localparam int TRIM_CYC = TRIM_US * (CLK_HZ / 1_000_000);
    localparam int DGL0_US  = 2;
    localparam int DGL1_US  = 4;
    localparam int DGL2_US  = 6;
    localparam int DGL3_US  = 8;
    localparam int DGL0_CYC = DGL0_US * (CLK_HZ / 1_000_000);
    localparam int DGL1_CYC = DGL1_US * (CLK_HZ / 1_000_000);
    localparam int DGL2_CYC = DGL2_US * (CLK_HZ / 1_000_000);
    localparam int DGL3_CYC = DGL3_US * (CLK_HZ / 1_000_000);

    // Per-channel amplifier control carrier
    typedef struct packed {
        logic [1:0] gain;      // Effective gain code
        logic       in_short;  // Inputs shorted
        logic       load_disc; // Load disconnected
        logic       trim_run;  // Automatic trim active
    } amp_ctrl_t;

endpackage

// ==== core/vds_ocp_and_amp_offset_cal.sv ====
// Overcurrent deglitch, amplifier setup and offset calibration with APB access
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module vds_ocp_and_amp_offset_cal
    import ocp_cal_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic [31:0]           prdata,
    input  wire logic [2:0]       hs_ds_over,
    input  wire logic [2:0]       ls_ds_over,
    input  wire logic             cal_pin,
    output logic [3:0]            ds_trip_level,
    output logic                  lowside_monitor_ref_sel,
    output logic                  vref_bidir,
    output amp_ctrl_t [2:0]       amp_ctrl,
    output logic [5:0]            ocp_event,
    output logic                  irq
);

    // Reset release synchroniser
    logic       rst_s1_q;
    logic       rst_n;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Pin synchronisers: 6 comparators and calibration pin
    logic [6:0] pin_s1_q;
    logic [6:0] pin_s2_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 7'h00;
            pin_s2_q <= 7'h00;
        end else begin
            pin_s1_q <= {cal_pin, ls_ds_over, hs_ds_over};
            pin_s2_q <= pin_s1_q;
        end
    end

    // High side: drain sense minus phase node, indices 0..2
    wire  [5:0] mon_over = pin_s2_q[5:0];
    wire        cal_pin_s = pin_s2_q[6];

    // Registers
    logic [CTRL_W-1:0] ctrl_q;
    logic [STAT_W-1:0] status_q;
    logic [STAT_W-1:0] mask_q;
    logic [STAT_W-1:0] rd_snap_q;  // Status bits returned by a read

    // Control field decode
    wire  [3:0] cfg_trip  = ctrl_q[TRIP_LSB +: 4];
    wire  [1:0] cfg_dgl   = ctrl_q[DGL_LSB +: 2];
    wire        cfg_lsref = ctrl_q[LSREF_BIT];
    wire  [1:0] cfg_gain  = ctrl_q[GAIN_LSB +: 2];
    wire        cfg_vdiv  = ctrl_q[VDIV_BIT];
    wire  [2:0] cfg_cal   = ctrl_q[CAL_LSB +: 3];

    // Per channel calibration: own bit or shared pin
    wire  [2:0] cal_act = cfg_cal | {3{cal_pin_s}};

    // APB decode
    wire        setup    = psel && !penable;
    wire        access   = psel && penable;
    wire        hit_ctrl = paddr == CTRL_OFS;
    wire        hit_stat = paddr == STATUS_OFS;
    wire        hit_mask = paddr == MASK_OFS;
    wire        hit_st   = paddr == STATE_OFS;
    wire        mapped   = hit_ctrl || hit_stat || hit_mask || hit_st;
    wire        wr_ctrl  = access && pwrite && hit_ctrl;
    wire        wr_mask  = access && pwrite && hit_mask;
    wire        rd_stat  = access && !pwrite && hit_stat;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // Deglitch limit from selection
    wire  [7:0] dgl_lim = (cfg_dgl == 2'h0) ? 8'(DGL0_CYC) :
                          (cfg_dgl == 2'h1) ? 8'(DGL1_CYC) :
                          (cfg_dgl == 2'h2) ? 8'(DGL2_CYC) :
                                              8'(DGL3_CYC);

    // Deglitch counters, one per MOSFET monitor
    logic [7:0]  dgl_cnt_q [6];
    logic [5:0]  ev_q;
    logic [11:0] trim_cnt_q [3];
    logic [2:0]  done_q;
    logic [2:0]  trim_run;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_dgl
            // Count cycles above trip, fire once on passing limit
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    dgl_cnt_q[gi] <= 8'h00;
                    ev_q[gi]      <= 1'b0;
                end else begin
                    ev_q[gi] <= mon_over[gi] && dgl_cnt_q[gi] == dgl_lim;
                    if (!mon_over[gi]) begin
                        dgl_cnt_q[gi] <= 8'h00;
                    end else if (dgl_cnt_q[gi] <= dgl_lim) begin
                        dgl_cnt_q[gi] <= dgl_cnt_q[gi] + 8'h01;
                    end
                end
            end
        end
        for (gi = 0; gi < 3; gi++) begin : g_trim
            // Trim timer runs from calibration start to fixed length
            assign trim_run[gi] = cal_act[gi] &&
                                  trim_cnt_q[gi] != 12'(TRIM_CYC);
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    trim_cnt_q[gi] <= 12'h000;
                    done_q[gi]     <= 1'b0;
                end else begin
                    done_q[gi] <= cal_act[gi] &&
                                  trim_cnt_q[gi] == 12'(TRIM_CYC - 1);
                    if (!cal_act[gi]) begin
                        trim_cnt_q[gi] <= 12'h000;
                    end else if (trim_run[gi]) begin
                        trim_cnt_q[gi] <= trim_cnt_q[gi] + 12'h001;
                    end
                end
            end
            // Amplifier controls; gain returns when request drops
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    amp_ctrl[gi] <= '0;
                end else begin
                    amp_ctrl[gi].gain      <= cal_act[gi] ? GAIN_40
                                                          : cfg_gain;
                    amp_ctrl[gi].in_short  <= cal_act[gi];
                    amp_ctrl[gi].load_disc <= cal_act[gi];
                    amp_ctrl[gi].trim_run  <= trim_run[gi];
                end
            end
        end
    endgenerate

    // Status next value: new events win over read clear
    wire  [STAT_W-1:0] new_ev   = {done_q, ev_q};
    wire  [STAT_W-1:0] status_d = (status_q & ~(rd_stat ? rd_snap_q : '0))
                                  | new_ev;

    // Read data selection
    wire  [31:0] rd_mux =
        hit_ctrl ? {19'h0, ctrl_q} :
        hit_stat ? {23'h0, status_q} :
        hit_mask ? {23'h0, mask_q} :
        hit_st   ? {20'h0, cal_act, trim_run, mon_over} : 32'h0;

    // Register file, read data and interrupt output
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q    <= CTRL_RST;
            mask_q    <= MASK_RST;
            status_q  <= STAT_RST;
            rd_snap_q <= STAT_RST;
            prdata    <= 32'h0;
            irq       <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[CTRL_W-1:0];
            end
            if (wr_mask) begin
                mask_q <= pwdata[STAT_W-1:0];
            end
            if (setup) begin
                prdata    <= rd_mux;
                rd_snap_q <= status_q;
            end
            status_q <= status_d;
            irq      <= |(status_d & mask_q);
        end
    end

    // Analogue configuration outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ds_trip_level           <= 4'h0;
            lowside_monitor_ref_sel <= 1'b0;
            vref_bidir              <= 1'b1;
        end else begin
            ds_trip_level           <= cfg_trip;
            lowside_monitor_ref_sel <= cfg_lsref;
            vref_bidir <= !cfg_vdiv || (|cal_act);
        end
    end
    assign ocp_event = ev_q;

    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_ev_cause;
        ev_q[0] |-> $past(mon_over[0]) && $past(dgl_cnt_q[0]) == $past(dgl_lim);
    endproperty
    a_ev_cause: assert property (p_ev_cause) else $error("early ocp");

    property p_no_ev_low;
        !mon_over[3] |=> !ev_q[3];
    endproperty
    a_no_ev_low: assert property (p_no_ev_low) else $error("ocp w/o over");

    property p_trip;
        ##1 ds_trip_level == $past(cfg_trip);
    endproperty
    a_trip: assert property (p_trip) else $error("trip stale");

    property p_lsref;
        ##1 lowside_monitor_ref_sel == $past(cfg_lsref);
    endproperty
    a_lsref: assert property (p_lsref) else $error("ref stale");

    property p_cal_gain;
        cal_act[1] |=> amp_ctrl[1].gain == GAIN_40 && amp_ctrl[1].in_short;
    endproperty
    a_cal_gain: assert property (p_cal_gain) else $error("cal gain");

    property p_trim_len;
        $rose(cal_act[0]) |-> (trim_run[0] == cal_act[0]) [*8];
    endproperty
    a_trim_len: assert property (p_trim_len) else $error("trim short");

    property p_hold;
        cal_act[0] && !trim_run[0] |=> amp_ctrl[0].load_disc
                                       && amp_ctrl[0].in_short;
    endproperty
    a_hold: assert property (p_hold) else $error("cal not held");

    property p_restore;
        !cal_act[0] |=> amp_ctrl[0].gain == $past(cfg_gain);
    endproperty
    a_restore: assert property (p_restore) else $error("gain lost");

    property p_bidir;
        (|cal_act) |=> vref_bidir;
    endproperty
    a_bidir: assert property (p_bidir) else $error("ref not bidir");

    property p_unidir;
        cfg_vdiv && !(|cal_act) |=> !vref_bidir;
    endproperty
    a_unidir: assert property (p_unidir) else $error("ref not unidir");

    property p_sticky;
        ev_q[1] |=> status_q[1];
    endproperty
    a_sticky: assert property (p_sticky) else $error("event lost");

    property p_trim_done;
        done_q[0] |-> $past(cal_act[0]) &&
                      $past(trim_cnt_q[0]) == 12'(TRIM_CYC - 1);
    endproperty
    a_trim_done: assert property (p_trim_done) else $error("trim end");

    property p_gain_cfg;
        !cal_act[2] |=> amp_ctrl[2].gain == $past(cfg_gain);
    endproperty
    a_gain_cfg: assert property (p_gain_cfg) else $error("gain cfg");

    property p_bid_all;
        cal_act[2] |=> vref_bidir;
    endproperty
    a_bid_all: assert property (p_bid_all) else $error("ref chan");

    property p_pin_cal;
        cal_pin_s |=> amp_ctrl[0].in_short && amp_ctrl[1].in_short
                      && amp_ctrl[2].in_short;
    endproperty
    a_pin_cal: assert property (p_pin_cal) else $error("pin cal");

    property p_own_cal;
        cfg_cal == 3'h1 && !cal_pin_s |=> !amp_ctrl[1].in_short
                                          && !amp_ctrl[2].in_short;
    endproperty
    a_own_cal: assert property (p_own_cal) else $error("cal leak");

    property p_irq;
        ##1 irq == |(status_q & $past(mask_q));
    endproperty
    a_irq: assert property (p_irq) else $error("irq level");

    property p_ls_ev;
        ev_q[5] |-> $past(mon_over[5]);
    endproperty
    a_ls_ev: assert property (p_ls_ev) else $error("ls ocp");

    property p_ov_clr;
        !mon_over[0] |=> dgl_cnt_q[0] == 8'h00;
    endproperty
    a_ov_clr: assert property (p_ov_clr) else $error("dgl reset");

endmodule

// ==== verif/bridge_model.sv ====
// Behavioural half-bridge comparators and controller calibration pin
`timescale 1ns/1ns
module bridge_model (
    input  wire logic       core_clk,
    output logic [2:0]      hs_ds_over,
    output logic [2:0]      ls_ds_over,
    output logic            cal_pin
);
    logic [5:0] over_q;  // Comparator levels, high side in low bits

    // Split levels onto high-side and low-side monitors
    assign hs_ds_over = over_q[2:0];
    assign ls_ds_over = over_q[5:3];

    // Quiet bridge and idle pin at start
    initial begin
        over_q = 6'h00;
        cal_pin = 1'b0;
    end

    // Hold one comparator above trip for len cycles
    task automatic trip(input int idx, input int len);
        @(posedge core_clk);
        over_q[idx] <= 1'b1;
        repeat (len) @(posedge core_clk);
        over_q[idx] <= 1'b0;
    endtask

    // Move calibration pin, only while bridges are quiet
    task automatic cal(input logic lvl);
        @(posedge core_clk);
        if (over_q == 6'h00) begin
            cal_pin <= lvl;
        end
    endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the overcurrent and calibration block
`timescale 1ns/1ns
module tb;
    import ocp_cal_pkg::*;
    logic            core_clk, arst_n, psel, penable, pwrite;
    logic            pready, pslverr, cal_pin, irq;
    logic            lowside_monitor_ref_sel, vref_bidir;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata;
    logic [2:0]      hs_ds_over, ls_ds_over;
    logic [3:0]      ds_trip_level;
    amp_ctrl_t [2:0] amp_ctrl;
    logic [5:0]      ocp_event, ev_last;
    logic [32:0]     exp_q[$];  // Expected {pslverr, prdata} per read
    logic [12:0]     c;  // Control word under test
    logic [31:0]     rnd = 32'h00010a01;  // Xorshift state
    int              error_cnt = 0, checked = 0, ev_cnt = 0, n0, dl;

    vds_ocp_and_amp_offset_cal dut (.core_clk(core_clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .hs_ds_over(hs_ds_over), .ls_ds_over(ls_ds_over),
        .cal_pin(cal_pin), .ds_trip_level(ds_trip_level),
        .lowside_monitor_ref_sel(lowside_monitor_ref_sel),
        .vref_bidir(vref_bidir), .amp_ctrl(amp_ctrl),
        .ocp_event(ocp_event), .irq(irq));
    bridge_model bridge (.core_clk(core_clk), .hs_ds_over(hs_ds_over),
        .ls_ds_over(ls_ds_over), .cal_pin(cal_pin));

    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic test_done();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    // Settled sampling point after n clocks
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // One APB transfer; reads leave their expectation in the queue
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exp_q.push_back(e);
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            error_cnt++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Compare read results and log event pulses
    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite) begin
            checked++;
            if (exp_q.size() == 0 || {pslverr, prdata} !== exp_q[0]) begin
                error_cnt++;
                $display("MISMATCH %0t read at %h", $time, paddr);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
        if (ocp_event != 6'h00) begin
            ev_cnt++;
            ev_last = ocp_event;
        end
    end

    // Main sequence
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        wt(4);
        apb(1'b0, CTRL_OFS, 32'h0, 33'h0);
        apb(1'b0, MASK_OFS, 32'h0, 33'h0);
        chk(vref_bidir === 1'b1, "bidir after reset");
        apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
        // Every gain code with random trip level and reference
        for (int g = 0; g < 4; g++) begin
            rnd = xs(rnd);
            c = {3'h0, rnd[7], 2'(g), rnd[6], 2'h0, rnd[3:0]};
            apb(1'b1, CTRL_OFS, {19'h0, c}, 33'h0);
            apb(1'b0, CTRL_OFS, 32'h0, {20'h0, c});
            wt(3);
            chk(ds_trip_level === c[3:0], "trip");
            chk(lowside_monitor_ref_sel === c[6], "ref");
            chk(amp_ctrl[1].gain === c[8:7], "gain");
            chk(vref_bidir === !c[9], "direction");
        end
        // Glitch then real overcurrent on each monitor
        apb(1'b1, MASK_OFS, 32'h1ff, 33'h0);
        for (int i = 0; i < 6; i++) begin
            n0 = ev_cnt;
            dl = (i % 4 + 1) * 50;
            apb(1'b1, CTRL_OFS, 32'(i % 4) << DGL_LSB, 33'h0);
            bridge.trip(i, dl - 5);
            wt(dl);
            chk(ev_cnt == n0, "glitch flagged");
            bridge.trip(i, dl + 10);
            wt(6);
            chk(ev_cnt == n0 + 1 && ev_last === 6'(1 << i), "event");
            chk(irq === 1'b1, "irq set");
            apb(1'b0, STATUS_OFS, 32'h0, 33'(1 << i));
            wt(3);
            chk(irq === 1'b0, "irq clear");
        end
        // Register calibration of channel 0, unidirectional setup
        apb(1'b1, CTRL_OFS, 32'h700, 33'h0);
        wt(3);
        chk(amp_ctrl[0] === {GAIN_40, 3'b111}, "cal on");
        chk(amp_ctrl[1] === {2'h2, 3'b000}, "other chan");
        chk(vref_bidir === 1'b1, "forced bidir");
        wt(TRIM_CYC);
        chk(amp_ctrl[0] === {GAIN_40, 3'b110}, "trim end");
        apb(1'b0, STATUS_OFS, 32'h0, 33'h40);
        apb(1'b1, CTRL_OFS, 32'h300, 33'h0);
        wt(3);
        chk(amp_ctrl[0] === {2'h2, 3'b000}, "restore");
        chk(vref_bidir === 1'b0, "unforced");
        // Pin calibration reaches all channels
        bridge.cal(1'b1);
        wt(5);
        chk(amp_ctrl[0].gain === GAIN_40 && amp_ctrl[2].gain === GAIN_40
            && amp_ctrl[1].in_short === 1'b1, "pin cal");
        bridge.cal(1'b0);
        wt(5);
        chk(amp_ctrl[2] === {2'h2, 3'b000}, "pin end");
        test_done();
    end

    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge core_clk);
        error_cnt++;
        test_done();
    end
endmodule
